// [src/sbd_pkg.sv]
package sbd_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_DATA = 3'h1;
  localparam logic [2:0] OFS_RATE = 3'h2;
  localparam logic [2:0] OFS_ERPR = 3'h6;
  localparam logic [2:0] OFS_ETPR = 3'h7;
  localparam logic [2:0] OFS_STAT = 3'h0;
  localparam int SCP_LSB = 6;
  localparam int SCT_LSB = 3;
  localparam int SCR_LSB = 0;
  localparam int STAT_TXRDY = 0;
  localparam int STAT_RXVAL = 1;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] EXT_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam int FIXED_DIV = 16;
  localparam int CLK_HZ = 25000000;
endpackage

// [src/sbd_rate_gen.sv]
`timescale 1ns/1ps
module sbd_rate_gen
  import sbd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [1:0] prescale_code,
  input  wire logic [2:0] divisor_code,
  input  wire logic [7:0] ext_value,
  output logic            rate_tick
);
  // chain: fixed /16, then prescaler, then power-of-two divisor or extended value
  logic [3:0]  fix_reg;
  logic [3:0]  pre_reg;
  logic [7:0]  div_reg;
  logic        fix_tick;
  logic        pre_tick;
  logic [3:0]  pre_max;
  logic [7:0]  div_max;

  always_comb begin
    case (prescale_code)
      2'h0:    pre_max = 4'h0;
      2'h1:    pre_max = 4'h2;
      2'h2:    pre_max = 4'h3;
      default: pre_max = 4'hC;
    endcase
  end
  // nonzero extended value replaces the divisor stage
  assign div_max = (ext_value != 8'h00) ? ext_value - 8'h01
                                        : 8'((9'h001 << divisor_code) - 9'h001);
  assign fix_tick = (fix_reg == 4'(FIXED_DIV - 1));
  assign pre_tick = fix_tick && (pre_reg >= pre_max);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      fix_reg <= 4'h0;
    end else begin
      fix_reg <= fix_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= 4'h0;
    end else if (fix_tick) begin
      pre_reg <= pre_tick ? 4'h0 : pre_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg   <= 8'h00;
      rate_tick <= 1'b0;
    end else begin
      rate_tick <= pre_tick && (div_reg >= div_max);
      if (pre_tick) begin
        div_reg <= (div_reg >= div_max) ? 8'h00 : div_reg + 8'h01;
      end
    end
  end
endmodule

// [src/sbd_data_path.sv]
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - one data address: write fills transmit buffer, read gives receive buffer
// - transmit buffer hands whole byte to shifter; receive buffer loads whole byte
// - transmit divisor code bits 5:3 divide by two to the power of code
// - receive divisor code bits 2:0 divide independently, same power-of-two coding
// - nonzero receive extended value divides the prescaler output by that value
// - nonzero transmit extended value divides the prescaler output by that value
// - after reset extended rate generator is off; conventional path only
module sbd_data_path
  import sbd_pkg::*;
#(
  parameter int DATA_W = 8
)(
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  output logic [DATA_W-1:0]      tx_shift_data,
  output logic                   tx_shift_valid,
  input  wire logic              tx_shift_ready,
  input  wire logic [DATA_W-1:0] rx_shift_data,
  input  wire logic              rx_shift_valid,
  output logic                   rx_shift_ready,
  output logic                   tx_rate_tick,
  output logic                   rx_rate_tick
);
  logic [7:0]        rate_reg;
  logic [7:0]        erpr_reg;
  logic [7:0]        etpr_reg;
  logic [DATA_W-1:0] txb_reg [2];
  logic [1:0]        txb_cnt_reg;
  logic              txb_rd_reg;
  logic [DATA_W-1:0] rxb_reg [2];
  logic [1:0]        rxb_cnt_reg;
  logic              rxb_rd_reg;
  logic              tx_push;
  logic              tx_pop;
  logic              rx_push;
  logic              rx_pop;
  logic              sel_data;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    return a == o;
  endfunction

  assign sel_data = hit(reg_addr, OFS_DATA);
  // two-entry buffer: a full transmit buffer drops further writes, visible in status
  assign tx_push = reg_wr && sel_data && (txb_cnt_reg != 2'h2);
  assign tx_pop  = tx_shift_valid && tx_shift_ready;
  assign tx_shift_valid = (txb_cnt_reg != 2'h0);
  assign tx_shift_data  = txb_reg[txb_rd_reg];
  assign rx_shift_ready = (rxb_cnt_reg != 2'h2);
  assign rx_push = rx_shift_valid && rx_shift_ready;
  assign rx_pop  = reg_rd && sel_data && (rxb_cnt_reg != 2'h0);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rate_reg <= RATE_RST;
      erpr_reg <= EXT_RST;
      etpr_reg <= EXT_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, OFS_RATE)) begin
        rate_reg <= reg_wdata;
      end
      if (hit(reg_addr, OFS_ERPR)) begin
        erpr_reg <= reg_wdata;
      end
      if (hit(reg_addr, OFS_ETPR)) begin
        etpr_reg <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      txb_reg[0]  <= '0;
      txb_reg[1]  <= '0;
      txb_cnt_reg <= 2'h0;
      txb_rd_reg  <= 1'b0;
    end else begin
      if (tx_push) begin
        txb_reg[txb_rd_reg ^ txb_cnt_reg[0]] <= reg_wdata[DATA_W-1:0];
      end
      if (tx_pop) begin
        txb_rd_reg <= ~txb_rd_reg;
      end
      txb_cnt_reg <= txb_cnt_reg + {1'b0, tx_push} - {1'b0, tx_pop};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxb_reg[0]  <= '0;
      rxb_reg[1]  <= '0;
      rxb_cnt_reg <= 2'h0;
      rxb_rd_reg  <= 1'b0;
    end else begin
      if (rx_push) begin
        rxb_reg[rxb_rd_reg ^ rxb_cnt_reg[0]] <= rx_shift_data;
      end
      if (rx_pop) begin
        rxb_rd_reg <= ~rxb_rd_reg;
      end
      rxb_cnt_reg <= rxb_cnt_reg + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= DATA_RST;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_DATA: reg_rdata <= 8'(rxb_reg[rxb_rd_reg]);
        OFS_RATE: reg_rdata <= rate_reg;
        OFS_ERPR: reg_rdata <= erpr_reg;
        OFS_ETPR: reg_rdata <= etpr_reg;
        OFS_STAT: reg_rdata <= 8'((2'(rxb_cnt_reg != 2'h0) << STAT_RXVAL)
                                  | (2'(txb_cnt_reg != 2'h2) << STAT_TXRDY));
        default:  reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  sbd_rate_gen u_tx_rate (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .prescale_code (rate_reg[SCP_LSB +: 2]),
    .divisor_code  (rate_reg[SCT_LSB +: 3]),
    .ext_value     (etpr_reg),
    .rate_tick     (tx_rate_tick)
  );

  sbd_rate_gen u_rx_rate (
    .ref_clk       (ref_clk),
    .arst_n        (arst_n),
    .prescale_code (rate_reg[SCP_LSB +: 2]),
    .divisor_code  (rate_reg[SCR_LSB +: 3]),
    .ext_value     (erpr_reg),
    .rate_tick     (rx_rate_tick)
  );

  a_tx_push_store: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tx_push && txb_cnt_reg == 2'h0 |=> tx_shift_valid && tx_shift_data == $past(reg_wdata))
    else $error("written byte not presented to shifter");
  a_rx_read_back: assert property (@(posedge ref_clk) disable iff (!arst_n)
    reg_rd && sel_data && rxb_cnt_reg != 2'h0 |=> reg_rdata == 8'($past(rxb_reg[rxb_rd_reg])))
    else $error("data read does not return receive buffer");
  a_rx_full_stall: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rxb_cnt_reg == 2'h2 |-> !rx_shift_ready)
    else $error("receive buffer accepts while full");
  a_rx_load_count: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rx_push && !rx_pop |=> rxb_cnt_reg == $past(rxb_cnt_reg) + 2'h1)
    else $error("receive load lost");
  // cycles since last tick; a counter, since a 16-cycle repetition is too long to unroll
  logic [7:0] tx_gap_reg;
  logic [7:0] rx_gap_reg;
  logic       tx_armed_reg;
  logic       rx_armed_reg;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_gap_reg   <= 8'h00;
      tx_armed_reg <= 1'b0;
    end else begin
      tx_gap_reg   <= tx_rate_tick ? 8'h00
                    : (tx_gap_reg == 8'hFF) ? tx_gap_reg : tx_gap_reg + 8'h01;
      tx_armed_reg <= (rate_reg == 8'h00) && (etpr_reg == 8'h00)
                      && (tx_armed_reg || tx_rate_tick);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_gap_reg   <= 8'h00;
      rx_armed_reg <= 1'b0;
    end else begin
      rx_gap_reg   <= rx_rate_tick ? 8'h00
                    : (rx_gap_reg == 8'hFF) ? rx_gap_reg : rx_gap_reg + 8'h01;
      rx_armed_reg <= (rate_reg == 8'h00) && (erpr_reg == 8'h00)
                      && (rx_armed_reg || rx_rate_tick);
    end
  end

  a_tx_fastest: assert property (@(posedge ref_clk) disable iff (!arst_n)
    tx_armed_reg && rate_reg == 8'h00 && etpr_reg == 8'h00
    |-> tx_rate_tick == (tx_gap_reg == 8'h0F))
    else $error("transmit rate not clock over 16");
  a_rx_fastest: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rx_armed_reg && rate_reg == 8'h00 && erpr_reg == 8'h00
    |-> rx_rate_tick == (rx_gap_reg == 8'h0F))
    else $error("receive rate not clock over 16");
  a_rx_ext_slow: assert property (@(posedge ref_clk) disable iff (!arst_n)
    erpr_reg == 8'h02 && $stable(erpr_reg) && $stable(rate_reg) && rx_rate_tick
    && rate_reg[7:6] == 2'h0 |=> !rx_rate_tick [*8])
    else $error("receive extended divide too fast");
  a_tx_ext_slow: assert property (@(posedge ref_clk) disable iff (!arst_n)
    etpr_reg == 8'h02 && $stable(etpr_reg) && $stable(rate_reg) && tx_rate_tick
    && rate_reg[7:6] == 2'h0 |=> !tx_rate_tick [*8])
    else $error("transmit extended divide too fast");
  a_ext_reset_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(arst_n) |-> erpr_reg == 8'h00 && etpr_reg == 8'h00)
    else $error("extended prescalers active after reset");
  a_rate_pair: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rate_reg[5:3] == rate_reg[2:0] && erpr_reg == etpr_reg && $stable(rate_reg)
    && $stable(erpr_reg) && $stable(etpr_reg) && tx_rate_tick |-> rx_rate_tick
    || $past(rate_reg) != rate_reg)
    else $error("equal settings give unequal rates");

  c_tx_full:  cover property (@(posedge ref_clk) txb_cnt_reg == 2'h2);
  c_rx_full:  cover property (@(posedge ref_clk) rxb_cnt_reg == 2'h2);
  c_rx_read:  cover property (@(posedge ref_clk) rx_pop);
  c_ext_tick: cover property (@(posedge ref_clk) erpr_reg != 8'h00 && rx_rate_tick);
endmodule

// [testbench/sbd_far_end.sv]
`timescale 1ns/1ps
module sbd_far_end (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       stall,
  input  wire logic       go,
  input  wire logic [7:0] go_byte,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready
);
  assign tx_ready = !stall;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else if (go) begin
      rx_valid <= 1'b1;
      rx_data  <= go_byte;
    end else if (rx_valid && rx_ready) begin
      rx_valid <= 1'b0;
      // no stale byte once released
      rx_data  <= ~rx_data;
    end
  end
endmodule

// [testbench/sbd_data_path_test.sv]
`timescale 1ns/1ps
module sbd_data_path_test;
  import sbd_pkg::*;
  logic        ref_clk, arst_n, reg_wr, reg_rd, stall, go, rd_d;
  logic        txv, txr, rxv, rxr, txt, rxt;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, txd, rxd, go_byte;
  logic [7:0]  rq[$], tq[$];
  logic [31:0] seed;
  int          err_count, tests_run;
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
  sbd_data_path sbd_data_path_inst (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_shift_data(txd), .tx_shift_valid(txv), .tx_shift_ready(txr), .rx_shift_data(rxd),
    .rx_shift_valid(rxv), .rx_shift_ready(rxr), .tx_rate_tick(txt), .rx_rate_tick(rxt));
  sbd_far_end sbd_far_end_inst (.ref_clk(ref_clk), .arst_n(arst_n), .stall(stall), .go(go),
    .go_byte(go_byte), .tx_ready(txr), .rx_data(rxd), .rx_valid(rxv), .rx_ready(rxr));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1) `CHK("rdata", rq.pop_front(), reg_rdata)
    if (txv && txr) `CHK("tx_data", tq.pop_front(), txd)
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic int pf(input logic [1:0] s);
    return (s == 2'h0) ? 1 : (s == 2'h1) ? 3 : (s == 2'h2) ? 4 : 13;
  endfunction
  task automatic results;
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // strobes stay as set until the next call, so no signal is driven twice per step
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic idle;
    bus(1'b0, 1'b0, 3'h0, 8'h00);
  endtask
  // first interval skipped: a divider may be mid-count after a write
  task automatic per(input logic r, input int e);
    int n, k, t;
    k = 0;
    t = 0;
    for (n = 0; n < 30000 && k < 3; n++) begin
      @(posedge ref_clk);
      if ((r ? rxt : txt) === 1'b1) begin
        k++;
        t = (k == 2) ? n : n - t;
      end
    end
    if (k < 3) begin
      err_count++;
      results();
    end
    `CHK("tick_period", e, t)
  endtask
  task automatic send(input logic [7:0] b);
    int n;
    for (n = 0; n < 50 && rxv === 1'b1; n++) @(posedge ref_clk);
    if (n == 50) begin
      err_count++;
      results();
    end
    go <= 1'b1;
    go_byte <= b;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial begin
    int i;
    logic [1:0] s;
    logic [7:0] b [3];
    {reg_wr, reg_rd, stall, go, arst_n} = '0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    go_byte = 8'h00;
    seed = 32'h43;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFS_RATE, RATE_RST);
    rd(OFS_ERPR, EXT_RST);
    rd(OFS_ETPR, EXT_RST);
    rd(3'h4, 8'h00);
    idle();
    per(1'b1, 16);
    for (i = 0; i < 8; i++) begin
      s = (i < 4) ? 2'(i) : 2'h0;
      bus(1'b1, 1'b0, OFS_RATE, {s, 3'(i), 3'(7 - i)});
      rd(OFS_RATE, {s, 3'(i), 3'(7 - i)});
      idle();
      fork
        per(1'b0, 16 * pf(s) * (1 << i));
        per(1'b1, 16 * pf(s) * (1 << (7 - i)));
      join
    end
    bus(1'b1, 1'b0, OFS_RATE, 8'h00);
    bus(1'b1, 1'b0, OFS_ETPR, 8'h23);
    bus(1'b1, 1'b0, OFS_ERPR, 8'hFF);
    idle();
    fork
      per(1'b0, 560);
      per(1'b1, 4080);
    join
    bus(1'b1, 1'b0, OFS_ETPR, 8'h00);
    idle();
    per(1'b0, 16);
    stall <= 1'b1;
    // third write meets a full buffer and is dropped
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      b[i] = seed[7:0];
      if (i < 2) tq.push_back(b[i]);
      bus(1'b1, 1'b0, OFS_DATA, b[i]);
    end
    rd(OFS_STAT, 8'h00);
    idle();
    stall <= 1'b0;
    for (i = 0; i < 20 && txv !== 1'b0; i++) @(posedge ref_clk);
    if (i == 20) begin
      err_count++;
      results();
    end
    @(posedge ref_clk);
    `CHK("tx_left", 0, tq.size())
    for (i = 0; i < 3; i++) begin
      seed = xs(seed);
      b[i] = seed[7:0];
      send(b[i]);
    end
    #1;
    `CHK("rx_ready", 1'b0, rxr)
    rd(OFS_STAT, 8'h03);
    rd(OFS_DATA, b[0]);
    rd(OFS_DATA, b[1]);
    idle();
    idle();
    rd(OFS_DATA, b[2]);
    idle();
    idle();
    results();
  end
endmodule
